//--- iph_pkg.sv
// Constants, types and state record of the interrupt priority handler
//------------------------------------------------------------------------------
// Summary of operation
// - Each source has a two-bit level, high bank bit over low bank bit, 00 lowest.
// - A running service is preempted only by a strictly higher level request.
// - Simultaneous requests of different levels: the higher level is served first.
// - Equal-level pending requests are resolved by a fixed polling order.
// - All flags are sampled and polled every machine cycle on the rising edge.
// - No hardware call while an equal or higher level service is in progress.
// - The hardware call is inserted only in the final cycle of an instruction.
// - After a return-from-interrupt, one more non-return instruction runs first.
// - A request whose flag has dropped when blocking ends is not served.
// - Vectoring pushes the program counter, loads the vector, does not save status.
// - Return-from-interrupt clears the current level's in-progress mark.
// - An ordinary return leaves the in-progress mark set.
// - The call lasts seven cycles and starts at least three cycles after request.
// - Final-cycle or return blocking adds eight cycles; longest instruction twenty.
// - Single-source response is at least three and below thirty-seven cycles.
// - Trigger select 0 requests on low level, 1 sets the flag on high-then-low.
// - Pins are sampled once per machine cycle; levels must last one cycle.
// - An edge-triggered flag clears automatically when its routine is vectored.
// - A level request still low after service raises another interrupt.
// - In level mode the external flag tracks the pin, no software clearing.
// - An enabled external interrupt wakes the device from idle or power-down.
// - Requests pass only while the global enable is set.
// - Third external input: 00 low, 01 falling, 10 rising, 11 both edges.
//------------------------------------------------------------------------------
package iph_pkg;

  localparam int NSRC = 12;

  // Register map
  localparam logic [7:0] ADDR_PRIO_HI0 = 8'hb4;
  localparam logic [7:0] ADDR_PRIO_HI1 = 8'hb5;
  localparam logic [7:0] ADDR_PRIO_LO0 = 8'hb8;
  localparam logic [7:0] ADDR_PRIO_LO1 = 8'hb9;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'hc0;
  localparam logic [7:0] ADDR_EXT_FLAG = 8'hc1;
  localparam logic [7:0] ADDR_ACTIVE   = 8'hc2;
  localparam logic [7:0] BANK0_MASK    = 8'h7f;
  localparam logic [7:0] BANK1_MASK    = 8'hb6;

  // External trigger codes and control field positions
  localparam logic [1:0] TRIG_LOW  = 2'h0;
  localparam logic [1:0] TRIG_FALL = 2'h1;
  localparam logic [1:0] TRIG_RISE = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;
  localparam int         IT0_BIT   = 0;
  localparam int         IT1_BIT   = 1;
  localparam int         IT2_LSB   = 2;

  // Per-source tables, index order is the polling order
  localparam logic [3:0]  EXT_SRC   [3]    = '{4'h0, 4'h2, 4'h8};
  localparam logic        PRIO_BANK [NSRC] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                              1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam logic [2:0]  PRIO_BIT  [NSRC] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6,
                                              3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
  localparam logic [15:0] VEC       [NSRC] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
                                              16'h0023, 16'h002b, 16'h0033, 16'h0043,
                                              16'h004b, 16'h005b, 16'h0063, 16'h0073};

  // Timing, one machine cycle per clock
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         MC_NS         = 10;
  localparam int         CALL_MC       = 7;
  localparam logic [2:0] CALL_CYCLES   = 3'(CALL_MC * MC_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {IPH_IDLE = 2'b01, IPH_CALL = 2'b10} iph_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } iph_bus_t;

  typedef struct packed {
    logic last_cycle;
    logic reti;
  } iph_cpu_t;

  typedef struct packed {
    iph_state_t  state;
    logic [2:0]  cnt;
    logic [7:0]  prio_hi0;
    logic [7:0]  prio_hi1;
    logic [7:0]  prio_lo0;
    logic [7:0]  prio_lo1;
    logic [3:0]  ext_ctrl;
    logic [2:0]  pin_prev;
    logic [2:0]  ext_flag;
    logic        poll_valid;
    logic [3:0]  poll_sel;
    logic [1:0]  poll_lvl;
    logic [3:0]  active;
    logic        reti_block;
    logic [15:0] vector;
    logic [11:0] ack;
    logic        call_start;
    logic [7:0]  rdata;
    logic        wake;
  } iph_regs_t;

endpackage

//--- iph_handler.sv
// Interrupt priority handler: flags, arbitration, hardware call and return
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module iph_handler
(
  input  wire logic             CORE_CLK_I,
  input  wire logic             ARST_N_I,
  input  wire iph_pkg::iph_bus_t BUS_I,
  output logic [7:0]            RDATA_O,
  input  wire iph_pkg::iph_cpu_t CPU_I,
  input  wire logic             GLOBAL_EN_I,
  input  wire logic [11:0]      SRC_EN_I,
  input  wire logic [8:0]       PERIPH_FLAG_I,
  input  wire logic [2:0]       EXT_PIN_I,
  input  wire logic             IDLE_I,
  input  wire logic             PDOWN_I,
  output logic                  CALL_START_O,
  output logic                  CALL_BUSY_O,
  output logic [15:0]           VECTOR_O,
  output logic [11:0]           ACK_O,
  output logic [3:0]            ACTIVE_O,
  output logic [2:0]            EXT_FLAG_O,
  output logic                  WAKE_O
);
  import iph_pkg::*;

  //----------------------------------------------------------------------------
  // Functions
  //----------------------------------------------------------------------------

  // Level of one source from the four priority banks
  function automatic logic [1:0] src_level(input logic [3:0] idx, input logic [7:0] h0,
                                            input logic [7:0] h1, input logic [7:0] l0,
                                            input logic [7:0] l1);
    logic [2:0] b;
    logic       hb;
    logic       lb;
    b  = PRIO_BIT[idx];
    hb = PRIO_BANK[idx] ? h1[b] : h0[b];
    lb = PRIO_BANK[idx] ? l1[b] : l0[b];
    return {hb, lb};
  endfunction

  // Highest level marked in progress, with a presence bit
  function automatic logic [2:0] top_level(input logic [3:0] act);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (act[i])
      begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  //----------------------------------------------------------------------------
  // State record and combinational helpers
  //----------------------------------------------------------------------------

  iph_regs_t   r_reg;
  iph_regs_t   r_next;
  logic [11:0] flags;
  logic [11:0] req;
  logic [2:0]  top;
  logic        arb_valid;
  logic [3:0]  arb_sel;
  logic [1:0]  arb_lvl;
  logic        reti_end;
  logic        call_ok;

  // Full flag vector in polling order
  assign flags = {PERIPH_FLAG_I[8:6], r_reg.ext_flag[2], PERIPH_FLAG_I[5:1],
                  r_reg.ext_flag[1], PERIPH_FLAG_I[0], r_reg.ext_flag[0]};
  // Masked by source and global enables
  assign req      = flags & SRC_EN_I & {12{GLOBAL_EN_I}};
  assign top      = top_level(r_reg.active);
  assign reti_end = CPU_I.last_cycle & CPU_I.reti;

  // Arbitration: highest level, then lowest polling rank
  always_comb
  begin
    arb_valid = 1'b0;
    arb_sel   = 4'h0;
    arb_lvl   = 2'h0;
    for (int lv = 0; lv < 4; lv++)
    begin
      for (int i = NSRC - 1; i >= 0; i--)
      begin
        if (req[i] && src_level(4'(i), r_reg.prio_hi0, r_reg.prio_hi1, r_reg.prio_lo0,
                                r_reg.prio_lo1) == 2'(lv) && (!top[2] || 2'(lv) > top[1:0]))
        begin
          arb_valid = 1'b1;
          arb_sel   = 4'(i);
          arb_lvl   = 2'(lv);
        end
      end
    end
  end

  // Call allowed only at an instruction end and not right after a return
  assign call_ok = (r_reg.state == IPH_IDLE) && r_reg.poll_valid && CPU_I.last_cycle &&
                   !CPU_I.reti && !r_reg.reti_block;

  //----------------------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------------------

  always_comb
  begin
    logic [1:0] trig;
    logic       pin;
    logic       prev;
    logic       evt;
    logic       clr;
    r_next            = r_reg;
    trig              = TRIG_LOW;
    pin               = 1'b1;
    prev              = 1'b1;
    evt               = 1'b0;
    clr               = 1'b0;
    r_next.call_start = 1'b0;
    r_next.ack        = 12'h000;
    r_next.rdata      = 8'h00;

    // Poll the currently valid requests every cycle
    r_next.poll_valid = arb_valid;
    r_next.poll_sel   = arb_sel;
    r_next.poll_lvl   = arb_lvl;

    // Call sequencer
    unique case (r_reg.state)
      IPH_IDLE:
      begin
        if (call_ok)
        begin
          r_next.state                   = IPH_CALL;
          r_next.cnt                     = CALL_CYCLES - 3'h1;
          r_next.call_start              = 1'b1;
          r_next.vector                  = VEC[r_reg.poll_sel];
          r_next.ack[r_reg.poll_sel]     = 1'b1;
          r_next.active[r_reg.poll_lvl]  = 1'b1;
        end
      end
      IPH_CALL:
      begin
        r_next.cnt = r_reg.cnt - 3'h1;
        if (r_reg.cnt == 3'h0)
        begin
          r_next.state = IPH_IDLE;
        end
      end
    endcase

    // Return blocking: one more ordinary instruction must complete
    if (reti_end)
    begin
      r_next.reti_block = 1'b1;
    end
    else if (CPU_I.last_cycle)
    begin
      r_next.reti_block = 1'b0;
    end

    // Only a return-from-interrupt clears the top in-progress level
    if (reti_end && top[2])
    begin
      r_next.active[top[1:0]] = 1'b0;
    end

    // External pins, sampled once per cycle
    r_next.pin_prev = EXT_PIN_I;
    for (int k = 0; k < 3; k++)
    begin
      pin  = EXT_PIN_I[k];
      prev = r_reg.pin_prev[k];
      if (k == 2)
      begin
        trig = r_reg.ext_ctrl[IT2_LSB +: 2];
      end
      else
      begin
        trig = r_reg.ext_ctrl[k] ? TRIG_FALL : TRIG_LOW;
      end
      evt = ((trig == TRIG_FALL) && prev && !pin) ||
            ((trig == TRIG_RISE) && !prev && pin) ||
            ((trig == TRIG_BOTH) && (prev != pin));
      clr = r_next.ack[EXT_SRC[k]] ||
            (BUS_I.wr && (BUS_I.addr == ADDR_EXT_FLAG) && BUS_I.wdata[k]);
      if (trig == TRIG_LOW)
      begin
        r_next.ext_flag[k] = !pin;
      end
      else
      begin
        r_next.ext_flag[k] = (r_reg.ext_flag[k] && !clr) || evt;
      end
    end

    // Wake from low-power modes on an enabled external request
    r_next.wake = (IDLE_I || PDOWN_I) &&
                  |(r_reg.ext_flag & {SRC_EN_I[EXT_SRC[2]], SRC_EN_I[EXT_SRC[1]],
                                      SRC_EN_I[EXT_SRC[0]]});

    // Register writes
    if (BUS_I.wr)
    begin
      unique case (BUS_I.addr)
        ADDR_PRIO_HI0: r_next.prio_hi0 = BUS_I.wdata & BANK0_MASK;
        ADDR_PRIO_HI1: r_next.prio_hi1 = BUS_I.wdata & BANK1_MASK;
        ADDR_PRIO_LO0: r_next.prio_lo0 = BUS_I.wdata & BANK0_MASK;
        ADDR_PRIO_LO1: r_next.prio_lo1 = BUS_I.wdata & BANK1_MASK;
        ADDR_EXT_CTRL: r_next.ext_ctrl = BUS_I.wdata[3:0];
        default:       r_next.ext_ctrl = r_next.ext_ctrl;
      endcase
    end

    // Register reads, data in the following cycle only
    if (BUS_I.rd)
    begin
      unique case (BUS_I.addr)
        ADDR_PRIO_HI0: r_next.rdata = r_reg.prio_hi0;
        ADDR_PRIO_HI1: r_next.rdata = r_reg.prio_hi1;
        ADDR_PRIO_LO0: r_next.rdata = r_reg.prio_lo0;
        ADDR_PRIO_LO1: r_next.rdata = r_reg.prio_lo1;
        ADDR_EXT_CTRL: r_next.rdata = {4'h0, r_reg.ext_ctrl};
        ADDR_EXT_FLAG: r_next.rdata = {5'h00, r_reg.ext_flag};
        ADDR_ACTIVE:   r_next.rdata = {4'h0, r_reg.active};
        default:       r_next.rdata = 8'h00;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      r_reg            <= '0;
      r_reg.state      <= IPH_IDLE;
      r_reg.pin_prev   <= 3'h7;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs
  assign RDATA_O      = r_reg.rdata;
  assign CALL_START_O = r_reg.call_start;
  assign CALL_BUSY_O  = (r_reg.state == IPH_CALL);
  assign VECTOR_O     = r_reg.vector;
  assign ACK_O        = r_reg.ack;
  assign ACTIVE_O     = r_reg.active;
  assign EXT_FLAG_O   = r_reg.ext_flag;
  assign WAKE_O       = r_reg.wake;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  sequence s_call_body;
    CALL_BUSY_O [*7] ##1 !CALL_BUSY_O;
  endsequence

  property p_call_len;
    $rose(CALL_BUSY_O) |-> s_call_body;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call length wrong");

  property p_final_cycle;
    CALL_START_O |-> $past(CPU_I.last_cycle);
  endproperty
  a_final_cycle: assert property (p_final_cycle) else $error("call not at instruction end");

  property p_after_reti;
    reti_end |=> !CALL_START_O;
  endproperty
  a_after_reti: assert property (p_after_reti) else $error("call right after return");

  property p_preempt;
    CALL_START_O |-> (!$past(top[2]) || ($past(r_reg.poll_lvl) > $past(top[1:0])));
  endproperty
  a_preempt: assert property (p_preempt) else $error("call at equal or lower level");

  property p_reti_clear;
    (reti_end && (r_reg.active != 4'h0)) |=>
      ($countones(r_reg.active) == $countones($past(r_reg.active)) - 1);
  endproperty
  a_reti_clear: assert property (p_reti_clear) else $error("return left level marked");

  property p_level_track;
    !r_reg.ext_ctrl[IT0_BIT] |=> (r_reg.ext_flag[0] == !$past(EXT_PIN_I[0]));
  endproperty
  a_level_track: assert property (p_level_track) else $error("level flag not tracking pin");

  property p_edge_set;
    (r_reg.ext_ctrl[IT1_BIT] && r_reg.pin_prev[1] && !EXT_PIN_I[1]) |=> r_reg.ext_flag[1];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("falling edge missed");

  property p_global;
    !GLOBAL_EN_I |=> !r_reg.poll_valid;
  endproperty
  a_global: assert property (p_global) else $error("request passed while disabled");

  property p_wake;
    (IDLE_I && SRC_EN_I[0] && r_reg.ext_flag[0]) |=> WAKE_O;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on external request");

endmodule

//--- iph_cpu_model.sv
// Behavioural CPU sequencer model: instruction boundaries and return marking
`timescale 1ns/1ns
module iph_cpu_model
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         busy_i,
  input  wire logic [4:0]   len_i,
  input  wire logic         reti_i,
  output iph_pkg::iph_cpu_t cpu_o
);
  import iph_pkg::*;

  logic [4:0] cnt;

  //----------------------------------------------------------------------------
  // Instruction sequencing
  //----------------------------------------------------------------------------
  // Cycle count inside the current instruction, held at zero during a call
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt <= 5'h00;
    else if (busy_i || cpu_o.last_cycle)
      cnt <= 5'h00;
    else
      cnt <= cnt + 5'h01;
  end

  // Final cycle flag, never raised while the hardware call runs
  assign cpu_o.last_cycle = !busy_i && ((cnt + 5'h01) >= len_i);
  // Return marking held for the whole returning instruction
  assign cpu_o.reti       = reti_i;
endmodule

//--- tb_interrupt_priority_handler.sv
// Self-checking bench for the interrupt priority handler
`timescale 1ns/1ns
module tb_interrupt_priority_handler;
  import iph_pkg::*;

  logic        clk;
  logic        rst_n;
  iph_bus_t    bus;
  iph_cpu_t    cpu;
  logic        gen;
  logic [8:0]  pflag;
  logic [8:0]  fset;
  logic [2:0]  pin;
  logic        idle;
  logic        pdown;
  logic        reti;
  logic [7:0]  rdata;
  logic        cstart;
  logic        cbusy;
  logic [15:0] vec;
  logic [11:0] ack;
  logic [3:0]  act;
  logic [2:0]  xflag;
  logic        wake;
  int          err_count;
  int          checked;
  int          n;
  int          b;

  iph_handler u_dut (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .BUS_I(bus), .RDATA_O(rdata),
    .CPU_I(cpu), .GLOBAL_EN_I(gen), .SRC_EN_I(12'hfff), .PERIPH_FLAG_I(pflag),
    .EXT_PIN_I(pin), .IDLE_I(idle), .PDOWN_I(pdown), .CALL_START_O(cstart),
    .CALL_BUSY_O(cbusy), .VECTOR_O(vec), .ACK_O(ack), .ACTIVE_O(act),
    .EXT_FLAG_O(xflag), .WAKE_O(wake));

  iph_cpu_model u_cpu (.clk_i(clk), .rst_n_i(rst_n), .busy_i(cbusy), .len_i(5'h01),
    .reti_i(reti), .cpu_o(cpu));

  //----------------------------------------------------------------------------
  // Clock and peripheral flags
  //----------------------------------------------------------------------------
  // Free running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Peripheral flags set by the bench, cleared when acknowledged
  always @(posedge clk)
    pflag <= (pflag | fset) & ~{ack[11:9], ack[7:3], ack[1]};

  //----------------------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------------------
  task automatic finish_test;
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      err_count++;
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1;
    cmp("read data", {8'h00, e}, {8'h00, rdata});
  endtask

  task automatic setf(input logic [8:0] m);
    @(posedge clk) fset <= m;
    @(posedge clk) fset <= 9'h000;
  endtask

  // Bounded wait for a call start, then vector check
  task automatic callw(input logic [15:0] v);
    for (n = 1; n <= 60; n++)
    begin
      tick(1);
      if (cstart === 1'b1)
        break;
    end
    if (n > 60)
    begin
      err_count++;
      finish_test();
    end
    cmp("vector", v, vec);
  endtask

  task automatic quiet(input int k);
    int m;
    m = 0;
    repeat (k)
    begin
      tick(1);
      if (cstart === 1'b1)
        m++;
    end
    cmp("unexpected calls", 16'h0000, 16'(m));
  endtask

  // One return-from-interrupt instruction after the call has ended
  task automatic do_reti;
    tick(8);
    @(posedge clk) reti <= 1'b1;
    @(posedge clk) reti <= 1'b0;
    #1;
  endtask

  //----------------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------------
  initial
  begin
    err_count = 0;
    checked = 0;
    rst_n = 1'b0;
    bus = '0;
    gen = 1'b1;
    pflag = 9'h000;
    fset = 9'h000;
    pin = 3'h7;
    idle = 1'b0;
    pdown = 1'b0;
    reti = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Priority registers: reset value, reserved bits, unmapped place
    rd(ADDR_PRIO_HI0, 8'h00);
    rd(ADDR_PRIO_LO1, 8'h00);
    wr(ADDR_PRIO_HI0, 8'hff);
    rd(ADDR_PRIO_HI0, 8'h7f);
    wr(ADDR_PRIO_HI1, 8'hff);
    rd(ADDR_PRIO_HI1, 8'hb6);
    rd(8'h37, 8'h00);
    wr(ADDR_PRIO_HI0, 8'h00);
    wr(ADDR_PRIO_HI1, 8'h00);
    // Falling edge on the first external input
    wr(ADDR_EXT_CTRL, 8'h01);
    @(posedge clk) pin[0] <= 1'b0;
    callw(16'h0003);
    cmp("latency", 16'h0003, 16'(n));
    cmp("ack", 16'h0001, {4'h0, ack});
    cmp("ext flag", 16'h0000, {15'h0000, xflag[0]});
    cmp("active", 16'h0001, {12'h000, act});
    busy_len();
    cmp("call length", 16'h0007, 16'(b));
    @(posedge clk) pin[0] <= 1'b1;
    do_reti();
    cmp("active", 16'h0000, {12'h000, act});
    // Different levels at once, then lower level waits
    wr(ADDR_PRIO_HI0, 8'h10);
    wr(ADDR_PRIO_LO0, 8'h10);
    wr(ADDR_EXT_CTRL, 8'h00);
    setf(9'h005);
    callw(16'h0023);
    cmp("active", 16'h0008, {12'h000, act});
    @(posedge clk) pin[0] <= 1'b0;
    tick(2);
    cmp("level flag", 16'h0001, {15'h0000, xflag[0]});
    quiet(12);
    @(posedge clk) pin[0] <= 1'b1;
    tick(2);
    cmp("level flag", 16'h0000, {15'h0000, xflag[0]});
    do_reti();
    callw(16'h000b);
    cmp("after return", 16'h0001, 16'(n > 1));
    do_reti();
    wr(ADDR_PRIO_HI0, 8'h00);
    wr(ADDR_PRIO_LO0, 8'h00);
    // Same level, polling order decides
    setf(9'h012);
    callw(16'h001b);
    do_reti();
    callw(16'h0033);
    do_reti();
    // Global enable masks every source
    @(posedge clk) gen <= 1'b0;
    setf(9'h001);
    quiet(20);
    @(posedge clk) gen <= 1'b1;
    callw(16'h000b);
    do_reti();
    // Level request in idle mode, repeated while held
    @(posedge clk)
    begin
      idle <= 1'b1;
      pin[1] <= 1'b0;
    end
    tick(2);
    cmp("wake", 16'h0001, {15'h0000, wake});
    callw(16'h0013);
    @(posedge clk)
    begin
      idle <= 1'b0;
      pdown <= 1'b1;
    end
    tick(1);
    cmp("wake", 16'h0001, {15'h0000, wake});
    @(posedge clk) pdown <= 1'b0;
    do_reti();
    callw(16'h0013);
    @(posedge clk) pin[1] <= 1'b1;
    do_reti();
    // Third input: falling ignored in rising mode, then falling in both-edge mode
    wr(ADDR_EXT_CTRL, {4'h0, TRIG_RISE, 2'h0});
    @(posedge clk) pin[2] <= 1'b0;
    quiet(5);
    @(posedge clk) pin[2] <= 1'b1;
    callw(16'h004b);
    do_reti();
    wr(ADDR_EXT_CTRL, {4'h0, TRIG_BOTH, 2'h0});
    @(posedge clk) pin[2] <= 1'b0;
    callw(16'h004b);
    do_reti();
    finish_test();
  end

  task automatic busy_len;
    b = 0;
    while (cbusy === 1'b1 && b < 20)
    begin
      b++;
      tick(1);
    end
  endtask
endmodule
